// File: qb_port_pkg.sv
package qb_port_pkg;
   localparam int PORT_W          = 8;
   localparam logic [7:0] LATCH_RESET = 8'hff;
   // Momentary strong high driver time
   localparam int STRONG_HI_NS    = 16;
   localparam int CLK_PERIOD_NS   = 8;
   localparam int STRONG_HI_CYC   = (STRONG_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Port 3 bit positions
   localparam int P3_SERIAL0_RECEIVE_IN = 0;
   localparam int P3_SERIAL0_TRANSMIT_OUT = 1;
   localparam int P3_IRQ0 = 2;
   localparam int P3_IRQ1 = 3;
   localparam int P3_TMR0 = 4;
   localparam int P3_TMR1 = 5;
   localparam int P3_WRS  = 6;
   localparam int P3_RDS  = 7;
   // Port 5 bit positions
   localparam int P5_CAN_ZERO_TRANSMIT = 0;
   localparam int P5_CAN_ZERO_RECEIVE = 1;
   localparam int P5_CAN_ONE_RECEIVE = 2;
   localparam int P5_CAN_ONE_TRANSMIT = 3;
   localparam int P5_PCE  = 4;

   // Latch write request for one port
   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } latch_wr_s;

   // Drive of one 8-bit port: strong low, strong high, weak pullup
   typedef struct packed {
      logic [7:0] strongLow;
      logic [7:0] strongHigh;
      logic [7:0] weakUp;
   } pin_drive_s;
endpackage

// File: qb_bit_cell.sv
`timescale 1ns/1ps
// One quasi-bidirectional port: latch, one-shot strong high, drive gating
module qb_bit_cell
   import qb_port_pkg::*;
#(
   parameter int W = 8
)(
   input  wire logic             ref_clk,     // Core clock
   input  wire logic             rst_n,       // Async reset, low
   input  wire logic             wrEn,        // Software latch write
   input  wire logic [W-1:0]     wrData,      // Value written
   input  wire logic [W-1:0]     altSel,      // Bit uses alternate output
   input  wire logic [W-1:0]     altOut,      // Alternate output level
   input  wire logic [W-1:0]     padIn,       // Pin level
   output logic      [W-1:0]     latchVal,    // Current latch
   output logic      [W-1:0]     readVal,     // Pin read value
   output logic      [W-1:0]     strongLow,   // Pulldown enable
   output logic      [W-1:0]     strongHigh,  // Transition driver
   output logic      [W-1:0]     weakUp       // Sustaining pullup
);
   localparam int CW = $clog2(STRONG_HI_CYC + 1);

   logic [W-1:0] latch_q;
   logic [W-1:0] latch_d;
   logic [W-1:0] level;
   logic [W-1:0] levelLast_q;

   assign latch_d = wrEn ? wrData : latch_q;
   // Latch gates alternate outputs; a zero latch always pulls low
   assign level   = latch_q & (~altSel | altOut);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latch_q     <= LATCH_RESET;
         levelLast_q <= LATCH_RESET;
      end
      else
      begin
         latch_q     <= latch_d;
         levelLast_q <= level;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic [CW-1:0] cnt_q;
         // Rising drive level fires the strong driver briefly
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
               cnt_q <= '0;
            else if (level[i] && !levelLast_q[i])
               cnt_q <= CW'(STRONG_HI_CYC);
            else if (cnt_q != '0)
               cnt_q <= cnt_q - 1'b1;
         end
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               strongLow[i]  <= 1'b0;
               strongHigh[i] <= 1'b0;
               weakUp[i]     <= 1'b1;
            end
            else
            begin
               strongLow[i]  <= ~level[i];
               strongHigh[i] <= level[i] && (!levelLast_q[i] || cnt_q > 1);
               weakUp[i]     <= level[i];
            end
         end
      end
   endgenerate

   assign latchVal = latch_q;
   assign readVal  = padIn;
endmodule // qb_bit_cell

// File: quasi_bidir_port_pins.sv
`timescale 1ns/1ps
module quasi_bidir_port_pins
   import qb_port_pkg::*;
(
   input  wire logic                 ref_clk,             // Core clock, 125 MHz
   input  wire logic                 rst_n,               // Async reset, low
   input  qb_port_pkg::latch_wr_s    p2Wr,                // Port 2 latch write
   input  qb_port_pkg::latch_wr_s    p3Wr,                // Port 3 latch write
   input  qb_port_pkg::latch_wr_s    p4Wr,                // Port 4 latch write
   input  qb_port_pkg::latch_wr_s    p5Wr,                // Port 5 latch write
   input  wire logic [7:0]           port4_config_reg,    // 1 = memory signal
   input  wire logic                 serial1_relocate_bit,// Serial 1 onto Port 5
   input  wire logic                 extAccess,           // External prog/data cycle
   input  wire logic                 external_data_move,  // 8-bit indirect move
   input  wire logic [7:0]           addrHigh,            // Address bits 15..8
   input  wire logic [3:0]           high_address_line,   // Address bits 19..16
   input  wire logic [3:0]           prog_mem_chip_enable,// Program CE 0..3
   input  wire logic [3:0]           periph_chip_enable,  // Peripheral CE 0..3
   input  wire logic                 serial0_transmit_out,// Serial 0 transmit
   input  wire logic                 serial1_transmit_out,// Serial 1 transmit
   input  wire logic                 timer_one_clock_out, // Clock out on Port 3.5
   input  wire logic                 timer_one_clock_en,  // Clock out selected
   input  wire logic                 writeStrobe,         // Data write strobe
   input  wire logic                 readStrobe,          // Data read strobe
   input  wire logic                 can_zero_transmit,   // CAN 0 transmit
   input  wire logic                 can_one_transmit,    // CAN 1 transmit
   input  wire logic [7:0]           p3PadIn,             // Port 3 pin levels
   input  wire logic [7:0]           p4PadIn,             // Port 4 pin levels
   input  wire logic [7:0]           p5PadIn,             // Port 5 pin levels
   output logic      [7:0]           p2PadOut,            // Port 2 pin drive
   output qb_port_pkg::pin_drive_s   p3Drive,             // Port 3 drive
   output qb_port_pkg::pin_drive_s   p4Drive,             // Port 4 drive
   output qb_port_pkg::pin_drive_s   p5Drive,             // Port 5 drive
   output logic      [7:0]           p3Read,              // Port 3 read value
   output logic      [7:0]           p4Read,              // Port 4 read value
   output logic      [7:0]           p5Read,              // Port 5 read value
   output logic      [7:0]           movxAddrHigh,        // Upper byte for moves
   output logic                      serial0_receive_in,  // From Port 3.0
   output logic                      ext_irq_zero,        // From Port 3.2
   output logic                      ext_irq_one,         // From Port 3.3
   output logic                      timer_zero_input,    // From Port 3.4
   output logic                      timer_one_input,     // From Port 3.5
   output logic                      can_zero_receive,    // From Port 5.1
   output logic                      can_one_receive,     // From Port 5.2
   output logic                      serial1_receive_in   // From Port 5.2 when moved
);
   import qb_port_pkg::*;

   logic [7:0] p2Latch;
   logic [7:0] p3Latch;
   logic [7:0] p4Latch;
   logic [7:0] p5Latch;
   logic [7:0] p3AltSel;
   logic [7:0] p3AltOut;
   logic [7:0] p5AltSel;
   logic [7:0] p5AltOut;
   logic [7:0] p2PadOut_d;
   logic       p5TxBit3;
   logic [7:0] p2Read;

   // Port 2 latch; drive pins with address during external cycles
   qb_bit_cell #(.W(PORT_W)) u_p2 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .wrEn       (p2Wr.wr),
      .wrData     (p2Wr.data),
      .altSel     (8'h00),
      .altOut     (8'h00),
      .padIn      (8'h00),
      .latchVal   (p2Latch),
      .readVal    (p2Read),
      .strongLow  (),
      .strongHigh (),
      .weakUp     ()
   );
   // Address only appears on Port 2; latch is for page moves alone
   assign p2PadOut_d = addrHigh;

   // Port 3 alternate outputs: transmit, clock out, strobes
   assign p3AltSel = {1'b1, 1'b1, timer_one_clock_en, 3'h0, 1'b1, 1'b0};
   assign p3AltOut = {readStrobe, writeStrobe, timer_one_clock_out, 3'h0,
                      serial0_transmit_out, 1'b0};

   qb_bit_cell #(.W(PORT_W)) u_p3 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .wrEn       (p3Wr.wr),
      .wrData     (p3Wr.data),
      .altSel     (p3AltSel),
      .altOut     (p3AltOut),
      .padIn      (p3PadIn),
      .latchVal   (p3Latch),
      .readVal    (p3Read),
      .strongLow  (p3Drive.strongLow),
      .strongHigh (p3Drive.strongHigh),
      .weakUp     (p3Drive.weakUp)
   );

   // Port 4: memory mode chosen per bit by configuration
   qb_bit_cell #(.W(PORT_W)) u_p4 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .wrEn       (p4Wr.wr),
      .wrData     (p4Wr.data),
      .altSel     (port4_config_reg),
      .altOut     ({high_address_line, prog_mem_chip_enable}),
      .padIn      (p4PadIn),
      .latchVal   (p4Latch),
      .readVal    (p4Read),
      .strongLow  (p4Drive.strongLow),
      .strongHigh (p4Drive.strongHigh),
      .weakUp     (p4Drive.weakUp)
   );

   // Port 5: CAN, peripheral enables, optional serial 1 on bit 3
   assign p5TxBit3 = serial1_relocate_bit ? serial1_transmit_out
                                          : can_one_transmit;
   assign p5AltSel = 8'hff & ~8'h06;
   assign p5AltOut = {periph_chip_enable, p5TxBit3, 2'b00, can_zero_transmit};

   qb_bit_cell #(.W(PORT_W)) u_p5 (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .wrEn       (p5Wr.wr),
      .wrData     (p5Wr.data),
      .altSel     (p5AltSel),
      .altOut     (p5AltOut),
      .padIn      (p5PadIn),
      .latchVal   (p5Latch),
      .readVal    (p5Read),
      .strongLow  (p5Drive.strongLow),
      .strongHigh (p5Drive.strongHigh),
      .weakUp     (p5Drive.weakUp)
   );

   // Registered pin outputs toward the core; inputs taken as synchronous
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p2PadOut           <= LATCH_RESET;
         movxAddrHigh       <= LATCH_RESET;
         serial0_receive_in <= 1'b1;
         ext_irq_zero       <= 1'b1;
         ext_irq_one        <= 1'b1;
         timer_zero_input   <= 1'b1;
         timer_one_input    <= 1'b1;
         can_zero_receive   <= 1'b1;
         can_one_receive    <= 1'b1;
         serial1_receive_in <= 1'b1;
      end
      else
      begin
         p2PadOut           <= extAccess ? p2PadOut_d : p2PadOut;
         movxAddrHigh       <= external_data_move ? p2Latch : addrHigh;
         serial0_receive_in <= p3PadIn[P3_SERIAL0_RECEIVE_IN];
         ext_irq_zero       <= p3PadIn[P3_IRQ0];
         ext_irq_one        <= p3PadIn[P3_IRQ1];
         timer_zero_input   <= p3PadIn[P3_TMR0];
         timer_one_input    <= p3PadIn[P3_TMR1];
         can_zero_receive   <= p5PadIn[P5_CAN_ZERO_RECEIVE];
         can_one_receive    <= serial1_relocate_bit ? 1'b1 : p5PadIn[P5_CAN_ONE_RECEIVE];
         serial1_receive_in <= serial1_relocate_bit ? p5PadIn[P5_CAN_ONE_RECEIVE] : 1'b1;
      end
   end
endmodule // quasi_bidir_port_pins

// File: qb_pin_ext.sv
`timescale 1ns/1ps
// Outside circuit on one port, able to pull pins low against the weak pullup
module qb_pin_ext
   import qb_port_pkg::*;
(
   input  qb_port_pkg::pin_drive_s drive,   // Drive from the port
   input  wire logic [7:0]         pullLow, // Outside pull-down
   output logic      [7:0]         pad      // Resolved pin level
);
   // Strong low wins; an undriven pin settles low rather than holding
   assign pad = ~drive.strongLow & ~pullLow & (drive.strongHigh | drive.weakUp);
endmodule // qb_pin_ext

// File: qb_port_chk_sva.sv
`timescale 1ns/1ps
// Pin behaviour seen from the block's ports only
module qb_port_chk
   import qb_port_pkg::*;
(
   input  wire logic               ref_clk,              // Core clock
   input  wire logic               rst_n,                // Async reset, low
   input  qb_port_pkg::latch_wr_s  p3Wr,                 // Port 3 write
   input  qb_port_pkg::pin_drive_s p3Drive,              // Port 3 drive
   input  qb_port_pkg::pin_drive_s p4Drive,              // Port 4 drive
   input  qb_port_pkg::pin_drive_s p5Drive,              // Port 5 drive
   input  wire logic [7:0]         p3PadIn,              // Port 3 pins
   input  wire logic [7:0]         p5PadIn,              // Port 5 pins
   input  wire logic [7:0]         p3Read,               // Port 3 read
   input  wire logic [7:0]         addrHigh,             // Address 15..8
   input  wire logic [7:0]         p2PadOut,             // Port 2 pins
   input  wire logic [7:0]         port4_config_reg,     // Port 4 mode
   input  wire logic [3:0]         prog_mem_chip_enable, // Program CEs
   input  wire logic               extAccess,            // External cycle
   input  wire logic               can_zero_transmit,    // CAN 0 out
   input  wire logic               serial1_relocate_bit, // Serial 1 moved
   input  wire logic               serial0_receive_in,   // Serial 0 in
   input  wire logic               can_one_receive,      // CAN 1 in
   input  wire logic               serial1_receive_in    // Serial 1 in
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Bit 2 has no alternate output, so its drive follows the latch alone
   a_zero_pulls_low: assert property (p3Wr.wr && !p3Wr.data[2] |-> ##2 p3Drive.strongLow[2])
      else $error("pulldown missing after zero write");
   a_one_weak_up: assert property (p3Wr.wr && p3Wr.data[2] |-> ##2 p3Drive.weakUp[2] && !p3Drive.strongLow[2])
      else $error("pullup missing after one write");
   a_strong_high_pulse: assert property ($rose(p3Drive.strongHigh[2]) |-> ##1 p3Drive.strongHigh[2] ##1 !p3Drive.strongHigh[2])
      else $error("strong high pulse length wrong");
   a_read_is_pin: assert property (p3Read == p3PadIn)
      else $error("read differs from pin");
   // Receive lines lag the pins by one edge; guard the edge after reset
   a_rx0_follows: assert property ($past(rst_n) |-> serial0_receive_in == $past(p3PadIn[0]))
      else $error("serial 0 receive not from pin");
   a_rx1_moved: assert property (serial1_relocate_bit && $past(serial1_relocate_bit) && $past(rst_n) |-> can_one_receive && serial1_receive_in == $past(p5PadIn[2]))
      else $error("relocated serial 1 receive wrong");
   // Port 2 shows the address during external cycles and holds it after
   a_p2_address: assert property (extAccess |=> p2PadOut == $past(addrHigh))
      else $error("port 2 not showing address");
   a_p2_holds: assert property (!extAccess |=> $stable(p2PadOut))
      else $error("port 2 changed outside access");
   // A low alternate output forces the pin low whatever the latch holds
   a_ce_forces_low: assert property ((port4_config_reg[0] && !prog_mem_chip_enable[0]) [*3] |-> p4Drive.strongLow[0])
      else $error("chip enable low not on pin");
   a_can_forces_low: assert property ((!can_zero_transmit) [*3] |-> p5Drive.strongLow[0])
      else $error("CAN transmit low not on pin");
endmodule // qb_port_chk

bind quasi_bidir_port_pins qb_port_chk qb_port_chk_inst (.*);

// File: test_quasi_bidir_port_pins.sv
`timescale 1ns/1ps
module test_quasi_bidir_port_pins;
   import qb_port_pkg::*;
   typedef struct {int k; logic [7:0] v;} note_s;
   logic       ref_clk = 1'h0, rst_n = 1'h0;
   latch_wr_s  p2Wr = '0, p3Wr = '0, p4Wr = '0, p5Wr = '0;
   logic [7:0] port4_config_reg = '0, addrHigh = '0, p3PadIn, p4PadIn, p5PadIn, p2PadOut;
   logic [7:0] p3Read, p4Read, p5Read, movxAddrHigh, e3 = '0, e4 = '0, e5 = '0, v3, v4, v5;
   logic [7:0] l2 = 8'hff, l3 = 8'hff, l4 = 8'hff, l5 = 8'hff, lastAddr = 8'hff;
   logic [3:0] high_address_line = '0, prog_mem_chip_enable = '0, periph_chip_enable = 4'hf;
   logic       serial1_relocate_bit = 1'h0, extAccess = 1'h0, external_data_move = 1'h0;
   logic       serial0_transmit_out = 1'h1, serial1_transmit_out = 1'h1, timer_one_clock_en = 1'h0;
   logic       timer_one_clock_out = 1'h1, writeStrobe = 1'h1, readStrobe = 1'h1;
   logic       can_zero_transmit = 1'h1, can_one_transmit = 1'h1, serial0_receive_in, ext_irq_zero;
   logic       ext_irq_one, timer_zero_input, timer_one_input, can_zero_receive, can_one_receive;
   logic       serial1_receive_in;
   logic [63:0] r;
   pin_drive_s p3Drive, p4Drive, p5Drive;
   note_s      q[$];
   note_s      nt;
   int         failures = 0, n_tests = 0;
   string      nm[13] = '{"p3Low", "p4Low", "p5Low", "p3Read", "movxHi", "p2Pad", "p3High",
                          "p3Weak", "rxMoved", "rxPlain", "irqTmr", "p4Read", "p5Read"};

   quasi_bidir_port_pins quasi_bidir_port_pins_inst (.*);
   qb_pin_ext ext3_inst (.drive(p3Drive), .pullLow(e3), .pad(p3PadIn));
   qb_pin_ext ext4_inst (.drive(p4Drive), .pullLow(e4), .pad(p4PadIn));
   qb_pin_ext ext5_inst (.drive(p5Drive), .pullLow(e5), .pad(p5PadIn));

   // Expected pin levels: latch gated by the alternate outputs
   assign v3 = l3 & (~(8'hc2 | {2'h0, timer_one_clock_en, 5'h00})
               | {readStrobe, writeStrobe, timer_one_clock_out, 3'h0, serial0_transmit_out, 1'h0});
   assign v4 = l4 & (~port4_config_reg | {high_address_line, prog_mem_chip_enable});
   assign v5 = l5 & (8'h06 | {periph_chip_enable,
               serial1_relocate_bit ? serial1_transmit_out : can_one_transmit, 2'h0, can_zero_transmit});

   always #4 ref_clk = ~ref_clk;

   function automatic logic [7:0] obs(int k);
      case (k)
         0: return p3Drive.strongLow;
         1: return p4Drive.strongLow;
         2: return p5Drive.strongLow;
         3: return p3Read;
         4: return movxAddrHigh;
         5: return p2PadOut;
         6: return p3Drive.strongHigh;
         7: return p3Drive.weakUp;
         8: return {4'h0, can_one_receive, serial1_receive_in, can_zero_receive, serial0_receive_in};
         10: return {4'h0, timer_one_input, timer_zero_input, ext_irq_one, ext_irq_zero};
         11: return p4Read;
         12: return p5Read;
         default: return {5'h0, can_one_receive, can_zero_receive, serial0_receive_in};
      endcase
   endfunction

   task automatic note(int k, logic [7:0] v);
      q.push_back('{k, v});
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // All four latches written in one pulse; order is Port 2, 3, 4, 5
   task automatic wr(logic [31:0] d);
      @(posedge ref_clk);
      {l2, l3, l4, l5} = d;
      p2Wr <= '{1'h1, d[31:24]};
      p3Wr <= '{1'h1, d[23:16]};
      p4Wr <= '{1'h1, d[15:8]};
      p5Wr <= '{1'h1, d[7:0]};
      @(posedge ref_clk);
      p2Wr <= '0;
      p3Wr <= '0;
      p4Wr <= '0;
      p5Wr <= '0;
   endtask

   task automatic wrap_up();
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Result side: every waiting note is compared once outputs have settled
   always @(negedge ref_clk)
   begin
      while (q.size() > 0)
      begin
         nt = q.pop_front();
         n_tests++;
         if (obs(nt.k) !== nt.v)
         begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm[nt.k], nt.v, obs(nt.k));
         end
      end
   end

   // Whole run is some 265 cycles; far past that means a hang
   initial
   begin
      tick(3000);
      failures++;
      wrap_up();
   end

   initial
   begin
      void'($urandom(14620));
      tick(10);
      rst_n <= 1'h1;
      tick(1);
      note(7, 8'hff);
      note(0, 8'h00);
      note(6, 8'h00);
      note(5, 8'hff);
      note(9, 8'h07);
      wr(32'hff00ffff);
      tick(3);
      note(0, 8'hff);
      wr(32'hffffffff);
      tick(1);
      note(6, 8'hff);
      tick(1);
      note(6, 8'hff);
      tick(1);
      note(6, 8'h00);
      note(7, 8'hff);
      // Random modes, alternate levels, outside pulls and latch values
      repeat (40)
      begin
         r = {$urandom, $urandom};
         @(posedge ref_clk);
         {port4_config_reg, addrHigh, high_address_line, prog_mem_chip_enable, periph_chip_enable,
          serial0_transmit_out, serial1_transmit_out, timer_one_clock_out, timer_one_clock_en,
          writeStrobe, readStrobe, can_zero_transmit, can_one_transmit, serial1_relocate_bit,
          extAccess, external_data_move} <= r[38:0];
         {e3, e4, e5} <= r[62:39];
         wr($urandom);
         tick(3);
         if (extAccess)
            lastAddr = addrHigh;
         note(0, ~v3);
         note(1, ~v4);
         note(2, ~v5);
         note(3, v3 & ~e3);
         note(11, v4 & ~e4);
         note(12, v5 & ~e5);
         note(10, {4'h0, v3[5:2] & ~e3[5:2]});
         note(4, external_data_move ? l2 : addrHigh);
         note(5, lastAddr);
         if (serial1_relocate_bit)
            note(8, {4'h1, (v5[2] & ~e5[2]), (v5[1] & ~e5[1]), (v3[0] & ~e3[0])});
         else
            note(9, {5'h0, (v5[2] & ~e5[2]), (v5[1] & ~e5[1]), (v3[0] & ~e3[0])});
      end
      @(posedge ref_clk);
      rst_n <= 1'h0;
      tick(1);
      note(0, 8'h00);
      note(7, 8'hff);
      tick(1);
      wrap_up();
   end
endmodule // test_quasi_bidir_port_pins
